/* File: verilog/iprt_pkg.sv */
// constants, types and carriers of the ip route table lookup block
`default_nettype none
package iprt_pkg;
  // table geometry
  localparam int             NUM_ENTRIES   = 16;
  localparam int             ENTRY_WORDS   = 6;
  localparam int             TABLE_WORDS   = 96;
  localparam logic [3:0]     LAST_ENTRY    = 4'hf;
  // register indexes, byte address is four times the index
  localparam logic [13:0]    ROUTE_DEST_HIGH_WORD_IDX = 14'hb54;
  localparam logic [13:0]    ROUTE_DEST_LOW_WORD_IDX  = 14'hb55;
  localparam logic [13:0]    ROUTE_MASK_HIGH_WORD_IDX = 14'hb56;
  localparam logic [13:0]    ROUTE_MASK_LOW_WORD_IDX  = 14'hb57;
  localparam logic [13:0]    ROUTE_EGRESS_PORT_IDX    = 14'hb58;
  localparam logic [13:0]    ROUTE_ACTION_FLAG_IDX    = 14'hb59;
  localparam logic [13:0]    TABLE_LAST_IDX           = 14'hbb3;
  localparam logic [13:0]    LOOKUP_STATUS_IDX        = 14'hc00;
  // word positions inside one entry
  localparam logic [6:0]     W_DEST_HI = 7'h00;
  localparam logic [6:0]     W_DEST_LO = 7'h01;
  localparam logic [6:0]     W_MASK_HI = 7'h02;
  localparam logic [6:0]     W_MASK_LO = 7'h03;
  localparam logic [6:0]     W_PORT    = 7'h04;
  localparam logic [6:0]     W_FLAG    = 7'h05;
  localparam logic [6:0]     W_STRIDE  = 7'h06;
  // flag and port values
  localparam logic [15:0]    FLAG_DISCARD  = 16'h0000;
  localparam logic [15:0]    FLAG_KEEP     = 16'h0001;
  localparam logic [15:0]    FLAG_FORWARD  = 16'h0002;
  localparam logic [15:0]    PORT_ETHERNET = 16'h0000;
  localparam logic [15:0]    WORD_RESET    = 16'h0000;
  // address class masks
  localparam logic [31:0]    MASK_CLASS_A = 32'hff000000;
  localparam logic [31:0]    MASK_CLASS_B = 32'hffff0000;
  localparam logic [31:0]    MASK_CLASS_C = 32'hffffff00;
  localparam logic [31:0]    MASK_NONE    = 32'hffffffff;
  localparam logic [31:0]    ADDR_ZERO    = 32'h00000000;
  // bus answers
  localparam logic [1:0]     RESP_OKAY   = 2'b00;
  localparam logic [1:0]     RESP_SLVERR = 2'b10;
  // lookup actions
  localparam logic [1:0]     ACT_DISCARD = 2'h0;
  localparam logic [1:0]     ACT_KEEP    = 2'h1;
  localparam logic [1:0]     ACT_FORWARD = 2'h2;
  // lookup state machine and search phase
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_DONE = 3'b100
  } iprt_state_t;
  typedef enum logic [2:0] {
    PH_EXACT   = 3'b001,
    PH_SUBNET  = 3'b010,
    PH_NETWORK = 3'b100
  } iprt_phase_t;
  // lookup request and answer
  typedef struct packed {
    logic [31:0] dest;
    logic        from_stack;
  } iprt_req_t;
  typedef struct packed {
    logic        hit;
    iprt_phase_t phase;
    logic [3:0]  entry;
    logic [1:0]  action;
    logic [15:0] port;
    logic [31:0] next_hop;
    logic        from_stack;
  } iprt_res_t;
endpackage
`default_nettype wire

/* File: verilog/iprt_lookup.sv */
// route table registers on axi4-lite and the route lookup engine
// Summary of operation
// - sixteen six-word entries at registers 2900..2995
// - local address entry uses keep flag 1
// - words three/four are mask or gateway
// - subnet route: subnet address plus gateway
// - no exact hit: search dest and local mask
// - network route uses class a/b/c mask
// - all-zero address is default, ends search
// - port word only 0, ethernet port
// - flag 0 discard, 1 keep, 2 forward
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module iprt_lookup
  import iprt_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // lookup request from packet path
  input  wire logic        lookup_valid,
  output logic             lookup_ready,
  input  wire iprt_req_t   lookup_req,
  // lookup answer
  output logic             res_valid,
  output var iprt_res_t    res_out
);
  // table storage, one word per register
  logic [15:0] tbl_reg [TABLE_WORDS];
  logic [15:0] tbl_next [TABLE_WORDS];
  // write channel state
  logic        awh_reg, awh_next;     // write address held
  logic [15:0] awa_reg, awa_next;
  logic        wh_reg, wh_next;       // write data held
  logic [31:0] wd_reg, wd_next;
  logic [3:0]  ws_reg, ws_next;
  logic        awrdy_reg, awrdy_next;
  logic        wrdy_reg, wrdy_next;
  logic        bv_reg, bv_next;
  logic [1:0]  br_reg, br_next;
  // read channel state
  logic        arrdy_reg, arrdy_next;
  logic        rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0]  rr_reg, rr_next;
  // lookup engine state
  iprt_state_t st_reg, st_next;
  iprt_phase_t ph_reg, ph_next;
  logic [3:0]  idx_reg, idx_next;     // entry under test
  logic [31:0] dest_reg, dest_next;
  logic        src_reg, src_next;
  logic [31:0] lmask_reg, lmask_next; // local subnet mask
  logic        lmf_reg, lmf_next;     // local mask found
  logic        lrdy_reg, lrdy_next;
  logic        rsv_reg, rsv_next;
  iprt_res_t   res_reg, res_next;
  // decode helpers
  logic [13:0] wr_idx, rd_idx;
  logic        wr_fire, wr_hit;
  logic [6:0]  wr_word, ebase;
  logic [31:0] e_addr, e_gw, cmask, target;
  logic [15:0] e_port, e_flag;

  // write decode: table words only accept writes
  assign wr_idx  = awa_reg[15:2];
  assign wr_fire = awh_reg && wh_reg && !bv_reg;
  assign wr_hit  = (wr_idx >= ROUTE_DEST_HIGH_WORD_IDX) && (wr_idx <= TABLE_LAST_IDX);
  assign wr_word = 7'(wr_idx - ROUTE_DEST_HIGH_WORD_IDX);
  assign rd_idx  = s_axi_araddr[15:2];

  // current entry fields in fixed word order
  assign ebase  = 7'({3'h0, idx_reg} * W_STRIDE);
  assign e_addr = {tbl_reg[ebase + W_DEST_HI], tbl_reg[ebase + W_DEST_LO]};
  assign e_gw   = {tbl_reg[ebase + W_MASK_HI], tbl_reg[ebase + W_MASK_LO]};
  assign e_port = tbl_reg[ebase + W_PORT];
  assign e_flag = tbl_reg[ebase + W_FLAG];

  // class mask from leading destination bits
  assign cmask = !dest_reg[31] ? MASK_CLASS_A :
                 !dest_reg[30] ? MASK_CLASS_B : MASK_CLASS_C;
  // compare value for each search phase
  assign target = (ph_reg == PH_EXACT)  ? dest_reg :
                  (ph_reg == PH_SUBNET) ? (dest_reg & lmask_reg) :
                  (dest_reg & cmask);

  // register read mux
  function automatic logic [31:0] read_word(input logic [13:0] i);
    logic [31:0] v;
    v = 32'h00000000;
    if ((i >= ROUTE_DEST_HIGH_WORD_IDX) && (i <= TABLE_LAST_IDX)) begin
      v[15:0] = tbl_reg[7'(i - ROUTE_DEST_HIGH_WORD_IDX)];
    end else if (i == LOOKUP_STATUS_IDX) begin
      v[0]     = (st_reg != ST_IDLE);
      v[2:1]   = res_reg.action;
      v[3]     = res_reg.hit;
      v[7:4]   = res_reg.entry;
      v[10:8]  = res_reg.phase;
      v[26:11] = res_reg.port;
    end
    return v;
  endfunction

  // write channel next state
  always_comb begin
    awh_next = awh_reg;
    awa_next = awa_reg;
    wh_next  = wh_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    if (s_axi_awvalid && awrdy_reg) begin
      awh_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_reg) begin
      wh_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (wr_fire) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    awrdy_next = !awh_next;
    wrdy_next  = !wh_next;
  end

  // table words next state, low byte lanes only
  always_comb begin
    tbl_next = tbl_reg;
    if (wr_fire && wr_hit) begin
      if (ws_reg[0]) begin
        tbl_next[wr_word][7:0] = wd_reg[7:0];
      end
      if (ws_reg[1]) begin
        tbl_next[wr_word][15:8] = wd_reg[15:8];
      end
    end
  end

  // read channel next state
  always_comb begin
    arrdy_next = arrdy_reg;
    rv_next    = rv_reg;
    rd_next    = rd_reg;
    rr_next    = rr_reg;
    // leave reset with the read address channel open
    if (!arrdy_reg && !rv_reg) begin
      arrdy_next = 1'b1;
    end
    if (s_axi_arvalid && arrdy_reg) begin
      arrdy_next = 1'b0;
      rv_next    = 1'b1;
      rd_next    = read_word(rd_idx);
      rr_next    = (((rd_idx >= ROUTE_DEST_HIGH_WORD_IDX) && (rd_idx <= TABLE_LAST_IDX))
                    || (rd_idx == LOOKUP_STATUS_IDX)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rv_reg && s_axi_rready) begin
      rv_next    = 1'b0;
      arrdy_next = 1'b1;
    end
  end

  // lookup engine next state
  always_comb begin
    st_next    = st_reg;
    ph_next    = ph_reg;
    idx_next   = idx_reg;
    dest_next  = dest_reg;
    src_next   = src_reg;
    lmask_next = lmask_reg;
    lmf_next   = lmf_reg;
    lrdy_next  = lrdy_reg;
    rsv_next   = 1'b0;
    res_next   = res_reg;
    case (st_reg)
      ST_IDLE: begin
        // take a request, start with exact phase
        if (lookup_valid && lrdy_reg) begin
          dest_next  = lookup_req.dest;
          src_next   = lookup_req.from_stack;
          idx_next   = 4'h0;
          ph_next    = PH_EXACT;
          lmask_next = MASK_NONE;
          lmf_next   = 1'b0;
          lrdy_next  = 1'b0;
          st_next    = ST_SCAN;
        end
      end
      ST_SCAN: begin
        // first keep entry supplies the local subnet mask
        if (ph_reg == PH_EXACT && e_flag == FLAG_KEEP && !lmf_reg) begin
          lmask_next = e_gw;
          lmf_next   = 1'b1;
        end
        res_next.phase      = ph_reg;
        res_next.entry      = idx_reg;
        res_next.port       = e_port;
        res_next.from_stack = src_reg;
        res_next.hit        = 1'b1;
        // exact hit reaches the destination itself, others the gateway
        res_next.next_hop   = (ph_reg == PH_EXACT) ? dest_reg : e_gw;
        case (e_flag)
          FLAG_KEEP:    res_next.action = ACT_KEEP;
          FLAG_FORWARD: res_next.action = (e_port == PORT_ETHERNET) ? ACT_FORWARD
                                          : ACT_DISCARD;
          default:      res_next.action = ACT_DISCARD;
        endcase
        if (e_addr == ADDR_ZERO) begin
          // zero address ends the table; default route only in last phase
          if (ph_reg == PH_NETWORK) begin
            rsv_next = 1'b1;
            st_next  = ST_DONE;
          end else begin
            ph_next  = (ph_reg == PH_EXACT) ? PH_SUBNET : PH_NETWORK;
            idx_next = 4'h0;
          end
        end else if (e_addr == target) begin
          rsv_next = 1'b1;
          st_next  = ST_DONE;
        end else if (idx_reg == LAST_ENTRY) begin
          if (ph_reg == PH_NETWORK) begin
            res_next.hit    = 1'b0;
            res_next.action = ACT_DISCARD;
            rsv_next        = 1'b1;
            st_next         = ST_DONE;
          end else begin
            ph_next  = (ph_reg == PH_EXACT) ? PH_SUBNET : PH_NETWORK;
            idx_next = 4'h0;
          end
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      ST_DONE: begin
        // answer shown this cycle, ready again next
        lrdy_next = 1'b1;
        st_next   = ST_IDLE;
      end
      default: begin
        st_next   = ST_IDLE;
        lrdy_next = 1'b1;
      end
    endcase
  end

  // registers of all groups
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl_reg   <= '{default: WORD_RESET};
      awh_reg   <= 1'b0;
      awa_reg   <= 16'h0000;
      wh_reg    <= 1'b0;
      wd_reg    <= 32'h00000000;
      ws_reg    <= 4'h0;
      awrdy_reg <= 1'b0;
      wrdy_reg  <= 1'b0;
      bv_reg    <= 1'b0;
      br_reg    <= RESP_OKAY;
      arrdy_reg <= 1'b0;
      rv_reg    <= 1'b0;
      rd_reg    <= 32'h00000000;
      rr_reg    <= RESP_OKAY;
      st_reg    <= ST_DONE;
      ph_reg    <= PH_EXACT;
      idx_reg   <= 4'h0;
      dest_reg  <= 32'h00000000;
      src_reg   <= 1'b0;
      lmask_reg <= MASK_NONE;
      lmf_reg   <= 1'b0;
      lrdy_reg  <= 1'b0;
      rsv_reg   <= 1'b0;
      res_reg   <= '{phase: PH_EXACT, default: '0};
    end else begin
      tbl_reg   <= tbl_next;
      awh_reg   <= awh_next;
      awa_reg   <= awa_next;
      wh_reg    <= wh_next;
      wd_reg    <= wd_next;
      ws_reg    <= ws_next;
      awrdy_reg <= awrdy_next;
      wrdy_reg  <= wrdy_next;
      bv_reg    <= bv_next;
      br_reg    <= br_next;
      arrdy_reg <= arrdy_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
      rr_reg    <= rr_next;
      st_reg    <= st_next;
      ph_reg    <= ph_next;
      idx_reg   <= idx_next;
      dest_reg  <= dest_next;
      src_reg   <= src_next;
      lmask_reg <= lmask_next;
      lmf_reg   <= lmf_next;
      lrdy_reg  <= lrdy_next;
      rsv_reg   <= rsv_next;
      res_reg   <= res_next;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awrdy_reg;
  assign s_axi_wready  = wrdy_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arrdy_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign lookup_ready  = lrdy_reg;
  assign res_valid     = rsv_reg;
  assign res_out       = res_reg;

  // checks
  a_scan_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    lookup_valid && lookup_ready |-> ##[2:49] res_valid)
    else $error("lookup answer missing");
  a_table_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_hit && ws_reg[1:0] == 2'h3 |=> tbl_reg[$past(wr_word)] == $past(wd_reg[15:0]))
    else $error("table word not written");
  a_subnet_target: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_SCAN && ph_reg == PH_SUBNET |-> target == (dest_reg & lmask_reg))
    else $error("subnet compare wrong");
  a_class_a_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_SCAN && ph_reg == PH_NETWORK && !dest_reg[31] |-> target[23:0] == 24'h000000)
    else $error("class mask wrong");
  a_default_end: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_SCAN && ph_reg == PH_NETWORK && e_addr == ADDR_ZERO
    |=> res_valid && res_out.hit && res_out.entry == $past(idx_reg))
    else $error("default route missed");
  a_port_only_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    res_valid && res_out.port != PORT_ETHERNET |-> res_out.action != ACT_FORWARD)
    else $error("forward to bad port");
  a_keep_action: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_SCAN && e_addr == target && e_addr != ADDR_ZERO && e_flag == FLAG_KEEP
    |=> res_valid && res_out.action == ACT_KEEP)
    else $error("keep action wrong");
  a_gateway_hop: assert property (@(posedge aclk) disable iff (!aresetn)
    res_valid && res_out.hit && res_out.phase != PH_EXACT |-> res_out.next_hop ==
    {tbl_reg[7'({3'h0, res_out.entry} * W_STRIDE) + W_MASK_HI],
     tbl_reg[7'({3'h0, res_out.entry} * W_STRIDE) + W_MASK_LO]})
    else $error("gateway hop wrong");
  a_exact_hop: assert property (@(posedge aclk) disable iff (!aresetn)
    res_valid && res_out.hit && res_out.phase == PH_EXACT |-> res_out.next_hop == dest_reg)
    else $error("exact hop wrong");
endmodule
`default_nettype wire

/* File: test/iprt_pkt_src.sv */
// packet path model: issues route lookups and collects the answers
`timescale 1ns/100ps
`default_nettype none
module iprt_pkt_src
  import iprt_pkg::*;
(
  // clock
  input  wire logic      aclk,
  // request side
  output logic           lookup_valid,
  input  wire logic      lookup_ready,
  output var iprt_req_t  lookup_req,
  // answer side
  input  wire logic      res_valid,
  input  wire iprt_res_t res_out
);
  // idle until the first request
  initial begin
    lookup_valid = 1'h0;
    lookup_req   = '0;
  end
  // one lookup: hold the request until taken, then wait for the answer pulse
  task automatic send(input logic [31:0] dest, input logic stack,
                      output iprt_res_t res, output logic ok);
    int n;
    ok  = 1'h0;
    res = '0;
    @(posedge aclk);
    lookup_valid <= 1'h1;
    lookup_req   <= '{dest: dest, from_stack: stack};
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (lookup_ready) break;
    end
    // released request must not keep showing the old address
    lookup_valid <= 1'h0;
    lookup_req   <= '{dest: ~dest, from_stack: ~stack};
    // answer pulse lasts one cycle, so look at every edge
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (res_valid) begin
        res = res_out;
        ok  = 1'h1;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: test/iprt_lookup_test.sv */
// self-checking bench of the route table lookup block
`timescale 1ns/100ps
`default_nettype none
module iprt_lookup_test;
  import iprt_pkg::*;
  logic        aclk, aresetn;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic        lookup_valid, lookup_ready, res_valid;
  iprt_req_t   lookup_req;
  iprt_res_t   res_out;
  int          n_fail, samples_checked;

  iprt_lookup DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lookup_valid(lookup_valid), .lookup_ready(lookup_ready),
    .lookup_req(lookup_req), .res_valid(res_valid), .res_out(res_out)
  );
  iprt_pkt_src src (
    .aclk(aclk), .lookup_valid(lookup_valid), .lookup_ready(lookup_ready),
    .lookup_req(lookup_req), .res_valid(res_valid), .res_out(res_out)
  );

  // 125 mhz clock
  always #4 aclk = ~aclk;

  // value compare, an unknown bit matches only an unknown bit
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // axi write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    r = 2'hx;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'h0;
  endtask

  // axi read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    d = 32'hx;
    r = 2'hx;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'h0;
  endtask

  // register write by index with response check
  task automatic wreg(input logic [13:0] i, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] e);
    logic [1:0] r;
    axi_wr({i, 2'h0}, d, s, r);
    chk("write response", {30'h0, e}, {30'h0, r});
  endtask

  // register read by index with data and response check
  task automatic rreg(input logic [13:0] i, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd({i, 2'h0}, d, r);
    chk("read response", {30'h0, er}, {30'h0, r});
    chk("read data", e, d);
  endtask

  // one six-word route entry
  task automatic put_entry(input int e, input logic [31:0] a, input logic [31:0] m,
                           input logic [15:0] p, input logic [15:0] f);
    logic [13:0] b;
    b = ROUTE_DEST_HIGH_WORD_IDX + 14'(e * 6);
    wreg(b, {16'h0, a[31:16]}, 4'h3, RESP_OKAY);
    wreg(b + 14'h1, {16'h0, a[15:0]}, 4'h3, RESP_OKAY);
    wreg(b + 14'h2, {16'h0, m[31:16]}, 4'h3, RESP_OKAY);
    wreg(b + 14'h3, {16'h0, m[15:0]}, 4'h3, RESP_OKAY);
    wreg(b + 14'h4, {16'h0, p}, 4'h3, RESP_OKAY);
    wreg(b + 14'h5, {16'h0, f}, 4'h3, RESP_OKAY);
  endtask

  // one lookup through the packet path model, fields and next hop compared
  task automatic look(input logic [31:0] dest, input logic st, input logic [2:0] ph,
                      input logic [3:0] ent, input logic [1:0] act, input logic [15:0] prt,
                      input logic [31:0] hop);
    iprt_res_t r;
    logic      ok;
    src.send(dest, st, r, ok);
    chk("result fields", {4'h0, ok, 1'h1, ph, ent, act, st, prt},
        {4'h0, ok, r.hit, r.phase, r.entry, r.action, r.from_stack, r.port});
    chk("next hop", hop, r.next_hop);
  endtask

  // table bounds, refusals, reset value, byte lanes
  task automatic test_regs();
    rreg(ROUTE_DEST_HIGH_WORD_IDX, 32'h0, RESP_OKAY);
    rreg(TABLE_LAST_IDX, 32'h0, RESP_OKAY);
    rreg(ROUTE_DEST_HIGH_WORD_IDX - 14'h1, 32'h0, RESP_SLVERR);
    rreg(TABLE_LAST_IDX + 14'h1, 32'h0, RESP_SLVERR);
    wreg(TABLE_LAST_IDX + 14'h1, 32'h1234, 4'h3, RESP_SLVERR);
    wreg(LOOKUP_STATUS_IDX, 32'h1, 4'h3, RESP_SLVERR);
    wreg(TABLE_LAST_IDX, 32'hdead0bad, 4'h3, RESP_OKAY);
    rreg(TABLE_LAST_IDX, 32'h00000bad, RESP_OKAY);
    wreg(TABLE_LAST_IDX, 32'h1234, 4'h1, RESP_OKAY);
    rreg(TABLE_LAST_IDX, 32'h00000b34, RESP_OKAY);
    wreg(TABLE_LAST_IDX, 32'h0, 4'h3, RESP_OKAY);
    $display("test_regs done");
  endtask

  // program the route table and read back the word order
  task automatic test_table();
    put_entry(0, 32'hc7bac314, 32'hffffff00, PORT_ETHERNET, FLAG_KEEP);
    put_entry(1, 32'hc7bac500, 32'hc7bac301, PORT_ETHERNET, FLAG_FORWARD);
    put_entry(2, 32'h0a000000, 32'hc7bac302, PORT_ETHERNET, FLAG_DISCARD);
    put_entry(3, 32'hac100000, 32'hc7bac303, 16'h0005, FLAG_FORWARD);
    put_entry(4, 32'h0, 32'hc7bac3fe, PORT_ETHERNET, FLAG_FORWARD);
    put_entry(5, 32'hc7bac3aa, 32'hffffffff, PORT_ETHERNET, FLAG_KEEP);
    rreg(ROUTE_DEST_HIGH_WORD_IDX + 14'h6, 32'h0000c7ba, RESP_OKAY);
    rreg(ROUTE_DEST_HIGH_WORD_IDX + 14'h9, 32'h0000c301, RESP_OKAY);
    $display("test_table done");
  endtask

  // back-to-back lookups over every phase and action
  task automatic test_lookups();
    look(32'hc7bac314, 1'h1, PH_EXACT, 4'h0, ACT_KEEP, PORT_ETHERNET, 32'hc7bac314);
    look(32'h0a000000, 1'h0, PH_EXACT, 4'h2, ACT_DISCARD, PORT_ETHERNET, 32'h0a000000);
    look(32'hc7bac577, 1'h0, PH_SUBNET, 4'h1, ACT_FORWARD, PORT_ETHERNET, 32'hc7bac301);
    look(32'h0a010203, 1'h0, PH_NETWORK, 4'h2, ACT_DISCARD, PORT_ETHERNET, 32'hc7bac302);
    look(32'hac10ffff, 1'h1, PH_NETWORK, 4'h3, ACT_DISCARD, 16'h0005, 32'hc7bac303);
    look(32'hc7bac3aa, 1'h0, PH_NETWORK, 4'h4, ACT_FORWARD, PORT_ETHERNET, 32'hc7bac3fe);
    // status: forward, hit, entry 4, network phase, port 0, not busy
    rreg(LOOKUP_STATUS_IDX, 32'h0000044c, RESP_OKAY);
    $display("test_lookups done");
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    n_fail          = 0;
    samples_checked = 0;
    aclk    = 1'h0;
    aresetn = 1'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    test_regs();
    test_table();
    test_lookups();
    // second reset clears the table
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rreg(ROUTE_DEST_HIGH_WORD_IDX, 32'h0, RESP_OKAY);
    // cleared table: entry 0 is an all-zero default route with discard flag
    look(32'h0a0b0c0d, 1'h0, PH_NETWORK, 4'h0, ACT_DISCARD, PORT_ETHERNET, 32'h0);
    $display("test_rereset done");
    complete_run();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
